/* File: common/gpio_port_pkg.sv */
// package for the port a / port c gpio block: register indices, field positions, reset values
// assumes an 8-bit register port driven by the core, data one cycle after a read strobe
package gpio_port_pkg;
   localparam int unsigned data_w = 8;
   localparam logic [3:0] addr_port_a_data = 4'h0;
   localparam logic [3:0] addr_port_a_direction = 4'h1;
   localparam logic [3:0] addr_pullup_enable = 4'h2;
   localparam logic [3:0] addr_change_irq_enable = 4'h3;
   localparam logic [3:0] addr_irq_control = 4'h4;
   localparam logic [3:0] addr_option = 4'h5;
   localparam logic [3:0] addr_port_c_data = 4'h6;
   localparam logic [3:0] addr_port_c_direction = 4'h7;
   localparam logic [3:0] addr_config = 4'h8;
   localparam logic [3:0] addr_bit_op = 4'h9;
   // port a bit 5 is the input-only / external reset pin
   localparam int unsigned reset_pin_bit = 5;
   // irq control fields
   localparam int unsigned flag_bit = 0;
   localparam int unsigned irq_en_bit = 3;
   // option field
   localparam int unsigned pullup_dis_bit = 7;
   // config field
   localparam int unsigned ext_reset_en_bit = 0;
   // bit operation register: [7] set/clear value, [2:0] bit index
   localparam int unsigned bitop_val_bit = 7;
   // port c alternate pins
   localparam int unsigned pc_radio_passthrough_data_in_bit = 0;
   localparam int unsigned pc_sclk_bit = 2;
   localparam int unsigned pc_cs_bit = 3;
   localparam int unsigned pc_sdio_bit = 4;
   // port a alternate pins
   localparam int unsigned pa_dbg_clk_bit = 0;
   localparam int unsigned pa_dbg_dat_bit = 1;
   localparam int unsigned pa_int_bit = 2;
   localparam int unsigned pa_xtal_bit = 7;
   localparam logic [7:0] dir_reset = 8'hff;
   localparam logic [7:0] zero_byte = 8'h00;
   localparam logic [7:0] pullup_reset = 8'hff;
   localparam logic [7:0] option_reset = 8'hff;
   localparam logic [7:0] config_reset = 8'h00;
   localparam logic [7:0] pa_alt_mask = 8'h87;
   localparam logic [7:0] pc_spi_mask = 8'h1c;
endpackage : gpio_port_pkg

/* File: test/gpio_port_with_change_irq_tb_top.sv */
// bench for the gpio block: register tasks, pin model, checks against a bench model
// assumes the pin model beside it and the register port with one-cycle read data
`timescale 1ns/10ps
`default_nettype none
module gpio_port_with_change_irq_tb_top;
   import gpio_port_pkg::*;
   logic core_clk = 1'b0, reset_n = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, ext_a = 8'h5a, ext_a_en = 8'hff, ext_c = 8'h00;
   logic [7:0] reg_rdata, port_a_in, port_a_out, port_a_oe_n, port_a_pullup_en;
   logic [7:0] port_c_in, port_c_out, port_c_oe_n, dir, outv;
   logic external_reset_pin, port_change_irq, wake_req, dbg_clk_in, dbg_dat_in;
   logic ext_int_in, timer0_clk_in, xtal_clk_in, radio_sdio_in, radio_passthrough_data_in;
   logic radio_sclk = 1'b0, radio_chip_select = 1'b1, radio_sdio_out = 1'b0;
   logic radio_sdio_oe_n = 1'b1, radio_passthrough_data_out = 1'b0;
   int seed = 32'h98bac424;
   int fail_count = 0;
   int comparisons = 0;
   always #4 core_clk = ~core_clk;
   gpio_port_with_change_irq gpio_port_with_change_irq_inst (.core_clk, .reset_n, .por_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_a_in, .port_a_out,
      .port_a_oe_n, .port_a_pullup_en, .port_c_in, .port_c_out, .port_c_oe_n,
      .external_reset_pin, .port_change_irq, .wake_req, .dbg_clk_in, .dbg_dat_in, .ext_int_in,
      .timer0_clk_in, .xtal_clk_in, .radio_sclk, .radio_chip_select, .radio_sdio_out,
      .radio_sdio_oe_n, .radio_passthrough_data_out, .radio_sdio_in, .radio_passthrough_data_in);
   pin_world_model pin_world_model_inst (.core_clk, .port_a_out, .port_a_oe_n,
      .port_a_pullup_en, .ext_a, .ext_a_en, .port_c_out, .port_c_oe_n, .ext_c, .port_a_in,
      .port_c_in);
   function automatic logic [7:0] pins();
      logic [7:0] de;
      de = dir | 8'h20;
      return (~de & outv) | (de & ext_a);
   endfunction : pins
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic results();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      results();
   end
   initial begin
      logic [7:0] d, p;
      int b;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      por_n <= 1'b1;
      #1;
      chk(port_a_oe_n, 8'hff);
      chk(port_a_pullup_en, 8'h00);
      rd(addr_change_irq_enable, d);
      chk(d, 8'h00);
      rd(4'hf, d);
      chk(d, 8'h00);
      // read data stand one cycle only, then fall back to zero
      @(posedge core_clk);
      #1 chk(reg_rdata, 8'h00);
      wr(addr_option, 8'h7f);
      for (int i = 0; i < 8; i++) begin
         dir = 8'($random(seed));
         outv = 8'($random(seed));
         d = 8'($random(seed));
         @(posedge core_clk) ext_a <= 8'($random(seed));
         wr(addr_pullup_enable, d);
         wr(addr_port_a_data, outv);
         wr(addr_port_a_direction, dir);
         settle();
         chk(port_a_out, outv & 8'hdf);
         chk(port_a_oe_n, dir | 8'h20);
         chk(port_a_pullup_en, d & dir & 8'hdf);
         p = pins();
         chk({3'h0, xtal_clk_in, timer0_clk_in, ext_int_in, dbg_dat_in, dbg_clk_in},
            {3'h0, p[7], p[2], p[2], p[1], p[0]});
         rd(addr_port_a_data, p);
         chk(p, pins());
      end
      wr(addr_option, 8'hff);
      settle();
      chk(port_a_pullup_en, 8'h00);
      wr(addr_option, 8'h7f);
      for (b = 0; b < 8; b++) begin
         p = pins();
         p[b] = b[0];
         wr(addr_bit_op, {b[0], 4'h0, b[2:0]});
         outv = p;
         settle();
         chk(port_a_out, outv & 8'hdf);
      end
      wr(addr_config, 8'h01);
      for (b = 0; b < 2; b++) begin
         @(posedge core_clk) ext_a[5] <= b[0];
         settle();
         chk(8'(external_reset_pin), 8'(b[0]));
         chk(port_a_pullup_en & 8'h20, 8'h20);
         rd(addr_port_a_data, p);
         chk(p & 8'h20, 8'h00);
      end
      wr(addr_config, 8'h00);
      // latch must outlive a pin reset: no flag when pins are unchanged
      wr(addr_port_a_direction, 8'hff);
      dir = 8'hff;
      rd(addr_port_a_data, p);
      @(posedge core_clk) reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      wr(addr_change_irq_enable, 8'hff);
      settle();
      rd(addr_irq_control, d);
      chk(d & 8'h09, 8'h00);
      @(posedge core_clk) ext_a <= ~ext_a;
      settle();
      rd(addr_irq_control, d);
      chk(d & 8'h09, 8'h01);
      chk(8'(wake_req), 8'h01);
      chk(8'(port_change_irq), 8'h00);
      wr(addr_irq_control, 8'h08);
      settle();
      rd(addr_irq_control, d);
      chk(d & 8'h09, 8'h09);
      chk(8'(port_change_irq), 8'h01);
      rd(addr_port_a_data, p);
      wr(addr_irq_control, 8'h08);
      settle();
      rd(addr_irq_control, d);
      chk(d & 8'h09, 8'h08);
      chk(8'(wake_req), 8'h00);
      wr(addr_port_c_direction, 8'hff);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         {radio_sclk, radio_chip_select, radio_sdio_out, radio_sdio_oe_n} <= 4'($random(seed));
         ext_c <= 8'($random(seed));
         settle();
         chk(port_c_out & 8'h1c,
            {3'h0, radio_sdio_out, radio_chip_select, radio_sclk, 2'h0});
         chk(port_c_oe_n & 8'h1c, {3'h0, radio_sdio_oe_n, 4'h0});
         chk({6'h0, radio_sdio_in, radio_passthrough_data_in},
            {6'h0, radio_sdio_oe_n ? ext_c[4] : radio_sdio_out, ext_c[0]});
         rd(addr_port_c_data, d);
         chk(d & 8'he3, ext_c & 8'he3);
      end
      results();
   end
endmodule : gpio_port_with_change_irq_tb_top
`default_nettype wire

/* File: test/pin_world_model.sv */
// pad model for the gpio block: resolves core driver, outside drive and weak pull-up
// assumes the bench gives outside drive values and a drive mask, one clock
`timescale 1ns/10ps
`default_nettype none
module pin_world_model (
   input wire logic core_clk,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe_n,
   input wire logic [7:0] port_a_pullup_en,
   input wire logic [7:0] ext_a,
   input wire logic [7:0] ext_a_en,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_oe_n,
   input wire logic [7:0] ext_c,
   output logic [7:0] port_a_in,
   output logic [7:0] port_c_in
);
   logic [7:0] float_r;
   // an undriven pad without pull-up wanders, so it never reads as steady
   always @(posedge core_clk) float_r <= (float_r === 8'h00) ? 8'hff : 8'h00;
   assign port_a_in = (~port_a_oe_n & port_a_out) | (port_a_oe_n & ext_a_en & ext_a) |
      (port_a_oe_n & ~ext_a_en & (port_a_pullup_en | float_r));
   assign port_c_in = (~port_c_oe_n & port_c_out) | (port_c_oe_n & ext_c);
endmodule : pin_world_model
`default_nettype wire

/* File: verilog/gpio_port_with_change_irq.sv */
// gpio block: 8-bit port a with pull-ups and pin-change flag, port c with radio spi muxing
// assumes synchronous pin inputs, registers reached by address/strobe port, one clock
// Function
// [R1] direction bit 1 makes the pin an input and turns its driver off
// [R2] direction bit 0 drives the pin from its output register bit
// [R3] port a data read returns live pin levels
// [R4] writes load output register; bit ops are read-modify-write from pins
// [R5] port a bit 5 is input only; its direction bit is ignored
// [R6] with external reset enabled, bit 5 is the reset pin and reads 0
// [R7] each port a pin except bit 5 has its own pull-up enable bit
// [R8] a pin configured as output has its pull-up forced off
// [R9] global pull-up disable in option register holds all pull-ups off
// [R10] bit 5 pull-up follows external reset mode: on as reset, off as io
// [R11] per-pin change enables, all cleared after power-on reset
// [R12] enabled pins mismatching last-read latch are ored into the change flag
// [R13] flag set each cycle while mismatch lasts; port read refreshes latch
// [R14] software reads or writes port a before clearing the flag
// [R15] last-read latch survives external-pin and brownout resets
// [R16] a set change flag raises the wake request
// [R17] pa0/pa1 carry debug clock/data; pa2 carries ext interrupt and timer clock
// [R18] pa7 also offers crystal and external clock input
// [R19] pc0 radio pass-through data; pc2, pc3, pc4 radio spi clock, select, data
// [R20] comparator functions on port c are not provided
// [R21] change flag raises interrupt only with its enable bit set
// [R22] writes to input bits still update the output register
// [R23] writing zero clears the flag; a same-cycle mismatch keeps it set
`timescale 1ns/10ps
`default_nettype none
module gpio_port_with_change_irq
   import gpio_port_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic por_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] port_a_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe_n,
   output logic [7:0] port_a_pullup_en,
   input wire logic [7:0] port_c_in,
   output logic [7:0] port_c_out,
   output logic [7:0] port_c_oe_n,
   output logic external_reset_pin,
   output logic port_change_irq,
   output logic wake_req,
   output logic dbg_clk_in,
   output logic dbg_dat_in,
   output logic ext_int_in,
   output logic timer0_clk_in,
   output logic xtal_clk_in,
   input wire logic radio_sclk,
   input wire logic radio_chip_select,
   input wire logic radio_sdio_out,
   input wire logic radio_sdio_oe_n,
   input wire logic radio_passthrough_data_out,
   output logic radio_sdio_in,
   output logic radio_passthrough_data_in
);

   logic [7:0] port_a_data_r;
   logic [7:0] port_a_direction_r;
   logic [7:0] pullup_enable_bits_r;
   logic [7:0] change_irq_enable_bits_r;
   logic [7:0] option_r;
   logic [7:0] user_config_word_r;
   logic [7:0] port_c_data_r;
   logic [7:0] port_c_direction_r;
   logic [7:0] last_read_r;
   logic port_change_flag_r;
   logic port_change_irq_enable_r;
   logic [7:0] rdata_nxt;

   // decode
   wire ext_reset_pin_enable = user_config_word_r[ext_reset_en_bit];
   wire pullup_global_disable = option_r[pullup_dis_bit];
   wire wr_pa = reg_wr && (reg_addr == addr_port_a_data);
   wire wr_bitop = reg_wr && (reg_addr == addr_bit_op);
   wire rd_pa = reg_rd && (reg_addr == addr_port_a_data);
   wire wr_irqc = reg_wr && (reg_addr == addr_irq_control);

   // bit 5 reads zero in reset mode
   wire [7:0] pa_pins;
   assign pa_pins = ext_reset_pin_enable ?
                    (port_a_in & ~(8'h01 << reset_pin_bit)) : port_a_in; // see [R6]

   // effective direction: bit 5 always input
   wire [7:0] pa_dir_eff = port_a_direction_r | (8'h01 << reset_pin_bit); // see [R5]

   // read-modify-write: pins read, one bit changed, stored to output register
   wire [7:0] bit_mask = 8'h01 << reg_wdata[2:0];
   wire [7:0] bitop_value = reg_wdata[bitop_val_bit] ?
                            (pa_pins | bit_mask) : (pa_pins & ~bit_mask); // see [R4]

   // mismatch against last read, enabled pins only
   wire [7:0] mismatch_bits = (pa_pins ^ last_read_r) & change_irq_enable_bits_r; // see [R12]
   wire mismatch = |mismatch_bits;

   // pull-up computation
   wire [7:0] pullup_nxt;
   genvar gi;
   generate
      for (gi = 0; gi < data_w; gi++) begin : g_pullup
         if (gi == reset_pin_bit) begin : g_rst
            assign pullup_nxt[gi] = ext_reset_pin_enable && !pullup_global_disable; // see [R10]
         end else begin : g_io
            // output pins lose their pull-up whatever the enable says
            assign pullup_nxt[gi] = pullup_enable_bits_r[gi] && pa_dir_eff[gi] &&
                                    !pullup_global_disable; // see [R7] see [R8] see [R9]
         end
      end
   endgenerate

   // port c: spi pins under radio control, comparator functions absent
   wire [7:0] pc_out_nxt;
   wire [7:0] pc_oe_n_nxt;
   assign pc_out_nxt = (port_c_data_r & ~pc_spi_mask)
                     | ({7'h00, radio_sclk} << pc_sclk_bit)
                     | ({7'h00, radio_chip_select} << pc_cs_bit)
                     | ({7'h00, radio_sdio_out} << pc_sdio_bit); // see [R19] see [R20]
   assign pc_oe_n_nxt = (port_c_direction_r & ~pc_spi_mask)
                      | ({7'h00, radio_sdio_oe_n} << pc_sdio_bit); // see [R19]

   // flag: set wins over clear
   wire flag_nxt = mismatch ? 1'b1 :
                   (wr_irqc ? reg_wdata[flag_bit] : port_change_flag_r); // see [R13] see [R23]

   // read mux
   always_comb begin
      case (reg_addr)
         addr_port_a_data: rdata_nxt = pa_pins; // see [R3]
         addr_port_a_direction: rdata_nxt = port_a_direction_r;
         addr_pullup_enable: rdata_nxt = pullup_enable_bits_r;
         addr_change_irq_enable: rdata_nxt = change_irq_enable_bits_r;
         addr_irq_control: rdata_nxt = ({7'h00, port_change_flag_r} << flag_bit)
                                     | ({7'h00, port_change_irq_enable_r} << irq_en_bit);
         addr_option: rdata_nxt = option_r;
         addr_port_c_data: rdata_nxt = port_c_in;
         addr_port_c_direction: rdata_nxt = port_c_direction_r;
         addr_config: rdata_nxt = user_config_word_r;
         default: rdata_nxt = zero_byte;
      endcase
   end

   // control registers, loaded with their reset values by reset_n only
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         port_a_data_r <= zero_byte;
         port_a_direction_r <= dir_reset;
         pullup_enable_bits_r <= pullup_reset;
         option_r <= option_reset;
         user_config_word_r <= config_reset;
         port_c_data_r <= zero_byte;
         port_c_direction_r <= dir_reset;
         port_change_irq_enable_r <= 1'b0;
         reg_rdata <= zero_byte;
      end else begin
         if (wr_pa) port_a_data_r <= reg_wdata; // see [R4] see [R22]
         else if (wr_bitop) port_a_data_r <= bitop_value; // see [R4]
         if (reg_wr && reg_addr == addr_port_a_direction) port_a_direction_r <= reg_wdata;
         if (reg_wr && reg_addr == addr_pullup_enable) pullup_enable_bits_r <= reg_wdata;
         if (reg_wr && reg_addr == addr_option) option_r <= reg_wdata;
         if (reg_wr && reg_addr == addr_config) user_config_word_r <= reg_wdata;
         if (reg_wr && reg_addr == addr_port_c_data) port_c_data_r <= reg_wdata;
         if (reg_wr && reg_addr == addr_port_c_direction) port_c_direction_r <= reg_wdata;
         if (wr_irqc) port_change_irq_enable_r <= reg_wdata[irq_en_bit];
         reg_rdata <= reg_rd ? rdata_nxt : zero_byte;
      end
   end

   // power-on-only state: the latch survives pin and brownout resets
   always_ff @(posedge core_clk) begin
      if (!por_n) begin
         last_read_r <= zero_byte;
         change_irq_enable_bits_r <= zero_byte; // see [R11]
         port_change_flag_r <= 1'b0;
      end else begin
         if (rd_pa || wr_pa || wr_bitop) last_read_r <= pa_pins; // see [R13] see [R14] see [R15]
         if (reg_wr && reg_addr == addr_change_irq_enable)
            change_irq_enable_bits_r <= reg_wdata; // see [R11]
         port_change_flag_r <= flag_nxt;
      end
   end

   // pin-side outputs, all registered
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         port_a_out <= zero_byte;
         port_a_oe_n <= dir_reset;
         port_a_pullup_en <= zero_byte;
         port_c_out <= zero_byte;
         port_c_oe_n <= dir_reset;
         external_reset_pin <= 1'b1;
         port_change_irq <= 1'b0;
         wake_req <= 1'b0;
         dbg_clk_in <= 1'b0;
         dbg_dat_in <= 1'b0;
         ext_int_in <= 1'b0;
         timer0_clk_in <= 1'b0;
         xtal_clk_in <= 1'b0;
         radio_sdio_in <= 1'b0;
         radio_passthrough_data_in <= 1'b0;
      end else begin
         port_a_out <= port_a_data_r & ~(8'h01 << reset_pin_bit); // see [R2]
         port_a_oe_n <= pa_dir_eff; // see [R1] see [R2] see [R5]
         port_a_pullup_en <= pullup_nxt;
         port_c_out <= pc_out_nxt;
         port_c_oe_n <= pc_oe_n_nxt;
         // reset pin held inactive high while used as plain io
         external_reset_pin <= ext_reset_pin_enable ? port_a_in[reset_pin_bit] : 1'b1; // see [R6]
         port_change_irq <= port_change_flag_r && port_change_irq_enable_r; // see [R21]
         wake_req <= port_change_flag_r; // see [R16]
         dbg_clk_in <= port_a_in[pa_dbg_clk_bit]; // see [R17]
         dbg_dat_in <= port_a_in[pa_dbg_dat_bit]; // see [R17]
         ext_int_in <= port_a_in[pa_int_bit]; // see [R17]
         timer0_clk_in <= port_a_in[pa_int_bit]; // see [R17]
         xtal_clk_in <= port_a_in[pa_xtal_bit]; // see [R18]
         radio_sdio_in <= port_c_in[pc_sdio_bit]; // see [R19]
         radio_passthrough_data_in <= port_c_in[pc_radio_passthrough_data_in_bit]; // see [R19]
      end
   end

   // checks
   dir_input_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> port_a_oe_n[reset_pin_bit]) // see [R5]
      else $error("bit 5 driver enabled");
   dir_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> port_a_oe_n == ($past(port_a_direction_r) | 8'h20)) // see [R1]
      else $error("driver enables do not follow direction");
   out_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_pa ##1 !(wr_bitop || wr_pa) |=> port_a_out == ($past(reg_wdata, 2) & 8'hdf)) // see [R2]
      else $error("pin output does not follow written value");
   pa_read_pins_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      rd_pa && !ext_reset_pin_enable |=> reg_rdata == $past(port_a_in)) // see [R3]
      else $error("port read not live pins");
   reset_pin_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      rd_pa && ext_reset_pin_enable |=> !reg_rdata[reset_pin_bit]) // see [R6]
      else $error("reset pin read as nonzero");
   pullup_output_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) && !$past(pa_dir_eff[3]) |-> !port_a_pullup_en[3]) // see [R8]
      else $error("pull-up on output pin");
   pullup_global_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) && $past(pullup_global_disable) |-> port_a_pullup_en == 8'h00) // see [R9]
      else $error("pull-up despite global disable");
   flag_set_a: assert property (@(posedge core_clk) disable iff (!por_n)
      mismatch |=> port_change_flag_r) // see [R12]
      else $error("mismatch did not set flag");
   flag_clear_a: assert property (@(posedge core_clk) disable iff (!por_n)
      wr_irqc && !reg_wdata[flag_bit] && !mismatch |=> !port_change_flag_r) // see [R23]
      else $error("flag not cleared");
   irq_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      port_change_irq |-> $past(port_change_irq_enable_r) && $past(port_change_flag_r)) // see [R21]
      else $error("irq without enable");
   latch_read_a: assert property (@(posedge core_clk) disable iff (!por_n)
      rd_pa |=> last_read_r == $past(pa_pins)) // see [R13]
      else $error("latch not refreshed on read");

   flag_seen_c: cover property (@(posedge core_clk) disable iff (!por_n)
      mismatch ##1 rd_pa ##2 wr_irqc ##1 !port_change_flag_r);
   bitop_c: cover property (@(posedge core_clk) disable iff (!reset_n) wr_bitop);
   irq_c: cover property (@(posedge core_clk) disable iff (!reset_n) port_change_irq);
   rst_mode_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      ext_reset_pin_enable && port_a_pullup_en[reset_pin_bit]);

endmodule : gpio_port_with_change_irq
`default_nettype wire
